/* design/ppm_port.sv */
// Purpose: Parallel port mode, timing, master sequencer and slave buffers.
// Assumes: AXI4-Lite slave; host pins sampled through two flip-flops.
// Notes: Writing the data register starts a master write; writing a
// one to bit 0 of the status register starts a master read.
// Overview of operation
// - Busy bit 15 shows master transfer.
// - Mode 10 interrupts on buffer three access.
// - Mode 01 per cycle, 00 none.
// - Step 11 advances the legacy slave buffer pointer.
// - Address bits 10:2 and 14 step.
// - Chip select line 14 excluded from stepping.
// - Master one: direction strobe plus enable.
// - Master two: separate read, write strobes.
// - Enhanced slave selects buffer by address.
// - Legacy slave: strobes and select only.
// - Setup lasts code plus one periods.
// - Strobe lasts code plus one periods.
// - Zero strobe code forces fixed setup/hold.
// - Unused bits read zero; reset clears.
module ppm_port
   import ppm_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // AXI4-Lite slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Port pins
   output logic chip_select_one_o,
   output logic read_strobe_o,
   output logic write_strobe_o,
   output logic enable_strobe_o,
   output logic [15:0] port_address_lines_o,
   output logic [7:0] port_data_lines_o,
   output logic port_data_lines_oe_n_o,
   input wire logic [7:0] port_data_lines_i,
   input wire logic read_strobe_i,
   input wire logic write_strobe_i,
   input wire logic chip_select_one_i,
   input wire logic [1:0] port_address_lines_i,
   // Events and configuration
   input wire logic cs1_on_a14_i,
   output logic irq_o
);
   logic [15:0] mode_q, mode_d;
   logic [15:0] addr_q, addr_d;
   logic [7:0] wdat_q, wdat_d, rdat_q, rdat_d;
   logic [7:0] buf_q [4];
   logic [7:0] buf_d [4];
   logic [1:0] ptr_q, ptr_d;
   ppm_state_t st_q, st_d;
   logic [4:0] cnt_q, cnt_d;
   logic dir_rd_q, dir_rd_d;
   logic awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, ar_q, ar_d, rv_q, rv_d;
   logic [31:0] rd_q, rd_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   logic cs_q, cs_d, rs_q, rs_d, ws_q, ws_d, en_q, en_d, oe_n_q, oe_n_d;
   logic irq_q, irq_d;
   logic [7:0] pd_q, pd_d;
   logic [4:0] sy1_q, sy2_q, syp_q;
   logic [7:0] dy1_q, dy2_q;
   logic [1:0] ay1_q, ay2_q;
   logic [4:0] setup_len, strobe_len, hold_len;
   logic [1:0] irq_request_select, stepm, pmode;
   logic master, wr_go, rd_go, s_rd, s_wr, s_end;
   logic cap1_q, cap1_d, cap2_q, cap2_d;
   logic [9:0] stp;

   assign irq_request_select = mode_q[PPM_IRQ_LSB +: 2];
   assign stepm = mode_q[PPM_STEP_LSB +: 2];
   assign pmode = mode_q[PPM_MODE_LSB +: 2];
   assign master = pmode[1];

   ppm_phase_timer u_timer (
      .setup_wait_count_i(mode_q[PPM_SETUP_LSB +: 2]),
      .strobe_wait_count_i(mode_q[PPM_STROBE_LSB +: 4]),
      .hold_wait_count_i(mode_q[PPM_HOLD_LSB +: 2]),
      .is_read_i(dir_rd_q),
      .setup_len_o(setup_len),
      .strobe_len_o(strobe_len),
      .hold_len_o(hold_len)
   );

   // Host pins are asynchronous, so only the second stage and the strobe edge stage after it are read.
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         // Idle pin levels, so no false strobe edge follows reset.
         sy1_q <= 5'h00;
         sy2_q <= 5'h00;
         syp_q <= 5'h00;
         dy1_q <= 8'h00;
         dy2_q <= 8'h00;
         ay1_q <= 2'h0;
         ay2_q <= 2'h0;
      end else begin
         sy1_q <= {cs1_on_a14_i, chip_select_one_i, read_strobe_i,
                   write_strobe_i, 1'b0};
         sy2_q <= sy1_q;
         syp_q <= sy2_q;
         dy1_q <= port_data_lines_i;
         dy2_q <= dy1_q;
         ay1_q <= port_address_lines_i;
         ay2_q <= ay2_q == ay1_q ? ay2_q : ay1_q;
      end
   end

   // Host strobes are active high here; a slave access ends on the fall.
   assign s_rd = ~master & sy2_q[3] & syp_q[2] & ~sy2_q[2];
   assign s_wr = ~master & sy2_q[3] & syp_q[1] & ~sy2_q[1];
   assign s_end = st_q == PPM_HOLD && cnt_q <= 5'h01 || st_q == PPM_STROBE
      && cnt_q == 5'h01 && hold_len == 5'h00;

   always_comb begin
      awr_d = awr_q;
      wr_d = wr_q;
      bv_d = bv_q;
      br_d = br_q;
      ar_d = ar_q;
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      mode_d = mode_q;
      addr_d = addr_q;
      wdat_d = wdat_q;
      rdat_d = rdat_q;
      buf_d = buf_q;
      ptr_d = ptr_q;
      wr_go = 1'b0;
      rd_go = 1'b0;
      cap1_d = st_q == PPM_STROBE && cnt_q == 5'h01 && dir_rd_q;
      cap2_d = cap1_q;
      stp = {addr_q[14], addr_q[10:2]};
      if (s_axi_awvalid && !awr_q && !bv_q) begin
         awr_d = 1'b1;
      end
      if (s_axi_wvalid && !wr_q && !bv_q) begin
         wr_d = 1'b1;
      end
      if (awr_q && wr_q) begin
         awr_d = 1'b0;
         wr_d = 1'b0;
         bv_d = 1'b1;
         br_d = PPM_RESP_OKAY;
         case (s_axi_awaddr)
            PPM_MODE_OFS: begin
               if (s_axi_wstrb[0]) begin
                  mode_d[7:0] = s_axi_wdata[7:0];
               end
               if (s_axi_wstrb[1]) begin
                  mode_d[15:8] = (s_axi_wdata[15:8] & PPM_MODE_WMASK[15:8])
                     | (mode_q[15:8] & ~PPM_MODE_WMASK[15:8]);
               end
            end
            PPM_ADDR_OFS: begin
               if (s_axi_wstrb[0]) begin
                  addr_d[7:0] = s_axi_wdata[7:0];
               end
               if (s_axi_wstrb[1]) begin
                  addr_d[15:8] = s_axi_wdata[15:8];
               end
            end
            PPM_DATA_OFS: begin
               if (s_axi_wstrb[0]) begin
                  wdat_d = s_axi_wdata[7:0];
                  buf_d[ptr_q] = s_axi_wdata[7:0];
                  wr_go = master && st_q == PPM_IDLE;
               end
            end
            PPM_STAT_OFS: begin
               rd_go = master && st_q == PPM_IDLE && s_axi_wdata[0];
            end
            default: br_d = PPM_RESP_SLVERR;
         endcase
      end
      if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      if (s_axi_arvalid && !ar_q && !rv_q) begin
         ar_d = 1'b1;
      end
      if (ar_q) begin
         ar_d = 1'b0;
         rv_d = 1'b1;
         rr_d = PPM_RESP_OKAY;
         case (s_axi_araddr)
            PPM_MODE_OFS: rd_d = {16'h0000,
               st_q != PPM_IDLE || cap1_q || cap2_q,
               mode_q[14:0]};
            PPM_ADDR_OFS: rd_d = {16'h0000, addr_q};
            PPM_DATA_OFS: rd_d = {24'h000000, master ? rdat_q : buf_q[ptr_q]};
            PPM_STAT_OFS: rd_d = {30'h0, ptr_q};
            default: begin
               rd_d = 32'h0000_0000;
               rr_d = PPM_RESP_SLVERR;
            end
         endcase
      end
      if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
      // Read data has passed the pin synchronisers, so it is taken two
      // cycles after the strobe ends; busy stays up until then.
      if (cap2_q) begin
         rdat_d = dy2_q;
      end
      // Bit 14 is the top of one counter with bits 10:2.
      if (s_end && (stepm == PPM_STEP_UP || stepm == PPM_STEP_DOWN)) begin
         if (stepm == PPM_STEP_UP) begin
            stp = stp + 10'h001;
         end else begin
            stp = stp - 10'h001;
         end
         addr_d[10:2] = stp[8:0];
         if (!sy2_q[4]) begin
            addr_d[14] = stp[9];
         end
      end
      if (s_wr) begin
         // Enhanced slave picks by address, legacy by the pointer.
         buf_d[pmode == PPM_PM_ENH ? ay2_q : ptr_q] = dy2_q;
      end
      if ((s_rd || s_wr) && pmode == PPM_PM_LEGACY
          && stepm == PPM_STEP_SLAVE) begin
         ptr_d = ptr_q + 2'h1;
      end
   end

   // Master sequencer.
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      dir_rd_d = dir_rd_q;
      case (st_q)
         PPM_IDLE: begin
            if (wr_go || rd_go) begin
               st_d = PPM_SETUP;
               dir_rd_d = rd_go;
               cnt_d = setup_len;
            end
         end
         PPM_SETUP: begin
            if (cnt_q <= 5'h01) begin
               st_d = PPM_STROBE;
               cnt_d = strobe_len;
            end else begin
               cnt_d = cnt_q - 5'h01;
            end
         end
         PPM_STROBE: begin
            if (cnt_q == 5'h01) begin
               st_d = hold_len == 5'h00 ? PPM_IDLE : PPM_HOLD;
               cnt_d = hold_len;
            end else begin
               cnt_d = cnt_q - 5'h01;
            end
         end
         PPM_HOLD: begin
            if (cnt_q <= 5'h01) begin
               st_d = PPM_IDLE;
            end else begin
               cnt_d = cnt_q - 5'h01;
            end
         end
         default: st_d = PPM_IDLE;
      endcase
   end

   // Pin drive and interrupt.
   always_comb begin
      logic act;
      act = st_d == PPM_STROBE;
      cs_d = master && st_d != PPM_IDLE;
      rs_d = 1'b0;
      ws_d = 1'b0;
      en_d = 1'b0;
      if (pmode == PPM_PM_MAST1) begin
         rs_d = cs_d && dir_rd_d;
         en_d = act;
      end else if (pmode == PPM_PM_MAST2) begin
         rs_d = act && dir_rd_d;
         ws_d = act && !dir_rd_d;
      end
      oe_n_d = 1'b1;
      pd_d = pd_q;
      if (master && st_d != PPM_IDLE && !dir_rd_d) begin
         oe_n_d = 1'b0;
         pd_d = wdat_q;
      end else if (!master && sy2_q[3] && sy2_q[2]) begin
         oe_n_d = 1'b0;
         pd_d = pmode == PPM_PM_ENH ? buf_q[ay2_q] : buf_q[ptr_q];
      end
      irq_d = 1'b0;
      case (irq_request_select)
         PPM_IRQ_CYCLE: irq_d = s_end || s_rd || s_wr;
         PPM_IRQ_BUF3: begin
            irq_d = (s_rd || s_wr) && (pmode == PPM_PM_ENH
               ? ay2_q == 2'h3 : ptr_q == 2'h3);
         end
         default: irq_d = 1'b0;
      endcase
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_q <= PPM_MODE_RESET[15:0];
         addr_q <= PPM_ADDR_RESET;
         wdat_q <= 8'h00;
         rdat_q <= 8'h00;
         for (int i = 0; i < 4; i++) begin
            buf_q[i] <= 8'h00;
         end
         ptr_q <= 2'h0;
         st_q <= PPM_IDLE;
         cnt_q <= 5'h00;
         dir_rd_q <= 1'b0;
         awr_q <= 1'b0;
         wr_q <= 1'b0;
         bv_q <= 1'b0;
         br_q <= 2'h0;
         ar_q <= 1'b0;
         rv_q <= 1'b0;
         rd_q <= 32'h0000_0000;
         rr_q <= 2'h0;
         cs_q <= 1'b0;
         rs_q <= 1'b0;
         ws_q <= 1'b0;
         en_q <= 1'b0;
         oe_n_q <= 1'b1;
         pd_q <= 8'h00;
         irq_q <= 1'b0;
         cap1_q <= 1'b0;
         cap2_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         addr_q <= addr_d;
         wdat_q <= wdat_d;
         rdat_q <= rdat_d;
         buf_q <= buf_d;
         ptr_q <= ptr_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         dir_rd_q <= dir_rd_d;
         awr_q <= awr_d;
         wr_q <= wr_d;
         bv_q <= bv_d;
         br_q <= br_d;
         ar_q <= ar_d;
         rv_q <= rv_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
         cs_q <= cs_d;
         rs_q <= rs_d;
         ws_q <= ws_d;
         en_q <= en_d;
         oe_n_q <= oe_n_d;
         pd_q <= pd_d;
         irq_q <= irq_d;
         cap1_q <= cap1_d;
         cap2_q <= cap2_d;
      end
   end

   assign s_axi_awready = awr_q;
   assign s_axi_wready = wr_q;
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = br_q;
   assign s_axi_arready = ar_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rr_q;
   assign chip_select_one_o = cs_q;
   assign read_strobe_o = rs_q;
   assign write_strobe_o = ws_q;
   assign enable_strobe_o = en_q;
   assign port_address_lines_o = addr_q;
   assign port_data_lines_o = pd_q;
   assign port_data_lines_oe_n_o = oe_n_q;
   assign irq_o = irq_q;
endmodule : ppm_port

/* design/ppm_pkg.sv */
// Purpose: Shared constants for the parallel port mode block.
// Assumes: AXI4-Lite register access, 32-bit data, 40 MHz clock.
// Notes: Offsets of the transfer registers are local choices.
package ppm_pkg;
   localparam logic [3:0] PPM_MODE_OFS = 4'h0;
   localparam logic [3:0] PPM_ADDR_OFS = 4'h4;
   localparam logic [3:0] PPM_DATA_OFS = 4'h8;
   localparam logic [3:0] PPM_STAT_OFS = 4'hc;
   localparam int PPM_BUSY_BIT = 15;
   localparam int PPM_IRQ_LSB = 13;
   localparam int PPM_STEP_LSB = 11;
   localparam int PPM_MODE_LSB = 8;
   localparam int PPM_SETUP_LSB = 6;
   localparam int PPM_STROBE_LSB = 2;
   localparam int PPM_HOLD_LSB = 0;
   localparam logic [15:0] PPM_MODE_WMASK = 16'h7bff;
   localparam logic [31:0] PPM_MODE_RESET = 32'h0000_0000;
   localparam logic [15:0] PPM_ADDR_RESET = 16'h0000;
   localparam logic [15:0] PPM_STEP_MASK = 16'h47fc;
   localparam logic [15:0] PPM_STEP_ONE = 16'h0004;
   localparam logic [1:0] PPM_IRQ_NONE = 2'h0;
   localparam logic [1:0] PPM_IRQ_CYCLE = 2'h1;
   localparam logic [1:0] PPM_IRQ_BUF3 = 2'h2;
   localparam logic [1:0] PPM_STEP_UP = 2'h1;
   localparam logic [1:0] PPM_STEP_DOWN = 2'h2;
   localparam logic [1:0] PPM_STEP_SLAVE = 2'h3;
   localparam logic [1:0] PPM_PM_LEGACY = 2'h0;
   localparam logic [1:0] PPM_PM_ENH = 2'h1;
   localparam logic [1:0] PPM_PM_MAST2 = 2'h2;
   localparam logic [1:0] PPM_PM_MAST1 = 2'h3;
   localparam logic [1:0] PPM_RESP_OKAY = 2'h0;
   localparam logic [1:0] PPM_RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {PPM_IDLE, PPM_SETUP, PPM_STROBE, PPM_HOLD}
      ppm_state_t;
endpackage : ppm_pkg

/* design/ppm_phase_timer.sv */
// Purpose: Phase lengths of one master transfer.
// Assumes: Fields come straight from the mode register.
// Notes: Lengths are in bus clock periods; hold may be zero.
module ppm_phase_timer
   import ppm_pkg::*;
(
   // Timing fields
   input wire logic [1:0] setup_wait_count_i,
   input wire logic [3:0] strobe_wait_count_i,
   input wire logic [1:0] hold_wait_count_i,
   input wire logic is_read_i,
   // Phase lengths
   output logic [4:0] setup_len_o,
   output logic [4:0] strobe_len_o,
   output logic [4:0] hold_len_o
);
   always_comb begin
      strobe_len_o = {1'b0, strobe_wait_count_i} + 5'h01;
      if (strobe_wait_count_i == 4'h0) begin
         setup_len_o = 5'h01;
         hold_len_o = is_read_i ? 5'h00 : 5'h01;
      end else begin
         setup_len_o = {3'h0, setup_wait_count_i} + 5'h01;
         hold_len_o = {3'h0, hold_wait_count_i} + 5'h01;
      end
   end
endmodule : ppm_phase_timer

/* tb/ppm_port_monitor.sv */
// Purpose: Assertions on the pins of the parallel port block.
// Assumes: One clock domain, reset asynchronous and active high.
// Notes: Strobe length is counted in helper logic, not unrolled.
module ppm_port_monitor (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Port pins
   input wire logic chip_select_one_o,
   input wire logic read_strobe_o,
   input wire logic write_strobe_o,
   input wire logic enable_strobe_o,
   input wire logic port_data_lines_oe_n_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] slen_q;
   logic [4:0] slen_d;
   logic stb;
   assign stb = write_strobe_o | enable_strobe_o;
   always_comb begin
      slen_d = stb ? slen_q + 5'h1 : 5'h0;
   end
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         slen_q <= 5'h0;
      end else begin
         slen_q <= slen_d;
      end
   end
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   chk_reset_idle: assert property (
      $fell(rst_i) |-> !chip_select_one_o && port_data_lines_oe_n_o
      && !irq_o) else $error("pins not idle after reset");
   chk_strobe_len: assert property (
      stb |-> slen_q < 5'h10) else $error("strobe longer than 16");
   chk_setup_first: assert property (
      $rose(chip_select_one_o) |-> !stb) else $error("no setup phase");
   chk_strobe_in_cs: assert property (
      stb |-> chip_select_one_o) else $error("strobe outside select");
   chk_rd_wr_excl: assert property (
      write_strobe_o |-> !read_strobe_o) else $error("both strobes");
   chk_write_drives: assert property (
      write_strobe_o |-> !port_data_lines_oe_n_o)
      else $error("write without data drive");
   chk_enable_drives: assert property (
      enable_strobe_o && !read_strobe_o |-> !port_data_lines_oe_n_o)
      else $error("enable write without data drive");
   chk_irq_pulse: assert property (
      irq_o |=> !irq_o) else $error("interrupt longer than a cycle");
   cov_write: cover property (write_strobe_o);
   cov_enable: cover property (enable_strobe_o);
   cov_irq: cover property (irq_o);
endmodule : ppm_port_monitor

bind ppm_port ppm_port_monitor ppm_port_monitor_inst (.*);

/* tb/ppm_host_model.sv */
// Purpose: Host and peripheral facing the parallel port pins.
// Assumes: Host strobes are active high levels.
// Notes: Undriven data lines churn so stale values never match.
module ppm_host_model (
   // Clock
   input wire logic mclk_i,
   // Port master side
   input wire logic chip_select_one_o,
   input wire logic port_data_lines_oe_n_o,
   input wire logic [7:0] port_data_lines_o,
   input wire logic [7:0] rd_val_i,
   // Host side
   output logic read_strobe_i,
   output logic write_strobe_i,
   output logic chip_select_one_i,
   output logic [1:0] port_address_lines_i,
   output logic [7:0] port_data_lines_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] host_d;
   logic [7:0] got;
   logic [7:0] churn;
   logic host_on;
   initial begin
      read_strobe_i = 1'b0;
      write_strobe_i = 1'b0;
      chip_select_one_i = 1'b0;
      port_address_lines_i = 2'h0;
      host_d = 8'h00;
      got = 8'h00;
      host_on = 1'b0;
      churn = 8'h00;
   end
   always @(posedge mclk_i) churn <= churn + 8'h3b;
   always_comb begin
      if (host_on) begin
         port_data_lines_i = host_d;
      end else if (chip_select_one_o && port_data_lines_oe_n_o) begin
         port_data_lines_i = rd_val_i;
      end else begin
         port_data_lines_i = churn;
      end
   end
   // One host access; the address is ignored in legacy mode.
   task automatic xfer(input logic w, input logic [1:0] a,
                       input logic [7:0] d);
      @(posedge mclk_i);
      chip_select_one_i <= 1'b1;
      port_address_lines_i <= a;
      host_d <= d;
      host_on <= w;
      repeat (2) @(posedge mclk_i);
      if (w) write_strobe_i <= 1'b1;
      else read_strobe_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      // A port that does not drive shows churn, which never matches.
      got <= port_data_lines_oe_n_o ? churn : port_data_lines_o;
      write_strobe_i <= 1'b0;
      read_strobe_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      chip_select_one_i <= 1'b0;
      host_on <= 1'b0;
      port_address_lines_i <= ~a;
      repeat (4) @(posedge mclk_i);
   endtask : xfer
endmodule : ppm_host_model

/* tb/ppm_port_test.sv */
// Purpose: Self-checking bench for the parallel port block.
// Assumes: Bench is the AXI4-Lite master; a host model sits on pins.
// Notes: Phase lengths are counted at the pins by the bench itself.
module ppm_port_test
   import ppm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [31:0] mw, mr;
      logic [15:0] a0, a1;
      logic a14;
      int su, stb, cs, irq;
   } ppm_row_t;
   logic mclk_i, rst_i, cs1_on_a14_i, irq_o, m11;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [1:0] s_axi_bresp, s_axi_rresp, port_address_lines_i, resp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, chip_select_one_o, read_strobe_o;
   logic write_strobe_o, enable_strobe_o, port_data_lines_oe_n_o;
   logic read_strobe_i, write_strobe_i, chip_select_one_i;
   logic [15:0] port_address_lines_o;
   logic [7:0] port_data_lines_o, port_data_lines_i, rd_val_i, last_d;
   int errors, compares, su_n, stb_n, cs_n, irqs;
   ppm_row_t r;
   ppm_row_t rows [5] = '{
      '{32'hffffbfff, 32'h3bff, 16'h8001, 16'h8001, 1'b0, 0, 0, 0, 0},
      '{32'h0a8d, 32'h0a8d, 16'h07fc, 16'h4000, 1'b0, 3, 4, 9, 0},
      '{32'h12c3, 32'h12c3, 16'h4004, 16'h4000, 1'b1, 1, 1, 3, 0},
      '{32'h333c, 32'h333c, 16'h4000, 16'h07fc, 1'b0, 1, 16, 18, 1},
      '{32'h03c6, 32'h03c6, 16'h1234, 16'h1234, 1'b1, 4, 2, 9, 0}};
   wire stb_w = write_strobe_o | enable_strobe_o | (read_strobe_o & !m11);

   ppm_port ppm_port_inst (.*);
   ppm_host_model ppm_host_model_inst (.*);

   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end
   // Phase lengths are counted from the pins, not taken from the design.
   always @(posedge mclk_i) begin
      if (chip_select_one_o === 1'b1) begin
         cs_n <= cs_n + 1;
         if (stb_w === 1'b1) begin
            stb_n <= stb_n + 1;
            last_d <= port_data_lines_o;
         end else if (stb_n == 0) su_n <= su_n + 1;
      end
      if (irq_o === 1'b1) irqs <= irqs + 1;
   end

   task automatic cmp(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk_i);
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge mclk_i);
         n++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 40);
      if (n == 40) errors++;
      s_axi_bready <= 1'b0;
      resp = s_axi_bresp;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      int n;
      @(posedge mclk_i);
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk_i);
         n++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 40);
      if (n == 40) errors++;
      s_axi_rready <= 1'b0;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
   endtask : rd
   task automatic clr();
      su_n <= 0;
      stb_n <= 0;
      cs_n <= 0;
      irqs <= 0;
   endtask : clr
   task automatic settle();
      int n;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (!(cs_n > 0 && chip_select_one_o === 1'b0) && n < 80);
      if (n == 80) errors++;
      repeat (2) @(posedge mclk_i);
   endtask : settle
   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
   endtask : do_reset
   task automatic tally_and_finish();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (6000) @(posedge mclk_i);
      errors++;
      tally_and_finish();
   end
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      {s_axi_bready, s_axi_rready, cs1_on_a14_i, m11} = '0;
      s_axi_wstrb = 4'hf;
      rd_val_i = 8'ha5;
      rst_i = 1'b1;
      clr();
      do_reset();
      rd(PPM_MODE_OFS);
      cmp("mode reset", 32'h0, rdat);
      rd(PPM_ADDR_OFS);
      cmp("addr reset", 32'h0, rdat);
      rd(4'h2);
      cmp("unmapped resp", PPM_RESP_SLVERR, resp);
      cmp("unmapped data", 32'h0, rdat);
      foreach (rows[i]) begin
         r = rows[i];
         m11 <= (r.mw[9:8] == 2'h3);
         cs1_on_a14_i <= r.a14;
         wr(PPM_MODE_OFS, r.mw);
         rd(PPM_MODE_OFS);
         cmp("mode", r.mr, rdat);
         wr(PPM_ADDR_OFS, {16'h0, r.a0});
         clr();
         if (r.su > 0) begin
            wr(PPM_DATA_OFS, 32'h5a);
            if (r.stb > 8) begin
               rd(PPM_MODE_OFS);
               cmp("busy", r.mr | 32'h8000, rdat);
            end
            settle();
            cmp("setup", r.su, su_n);
            cmp("strobe", r.stb, stb_n);
            cmp("wdata", 32'h5a, last_d);
            if (r.cs > 0) cmp("cs", r.cs, cs_n);
            cmp("irq", r.irq, irqs);
            rd(PPM_MODE_OFS);
            cmp("idle", r.mr, rdat);
         end
         rd(PPM_ADDR_OFS);
         cmp("addr", {16'h0, r.a1}, rdat);
      end
      m11 <= 1'b0;
      wr(PPM_MODE_OFS, 32'h0200);
      clr();
      wr(PPM_STAT_OFS, 32'h1);
      settle();
      cmp("rd setup", 1, su_n);
      cmp("rd strobe", 1, stb_n);
      cmp("rd cs", 2, cs_n);
      rd(PPM_DATA_OFS);
      cmp("rdata", 32'ha5, rdat);
      wr(PPM_MODE_OFS, 32'h5800);
      clr();
      for (int i = 0; i < 4; i++) begin
         ppm_host_model_inst.xfer(1'b0, 2'h0, 8'h00);
         rd(PPM_STAT_OFS);
         cmp("rptr", (i + 1) % 4, rdat & 32'h3);
         cmp("buf irq", (i == 3), irqs);
      end
      wr(PPM_MODE_OFS, 32'h4100);
      for (int a = 0; a < 4; a++) begin
         clr();
         ppm_host_model_inst.xfer(1'b1, 2'(a), 8'(8'h30 + a));
         ppm_host_model_inst.xfer(1'b0, 2'(a), 8'h00);
         cmp("slave rdata", 32'(8'h30 + a), ppm_host_model_inst.got);
         cmp("addr irq", (a == 3) ? 2 : 0, irqs);
      end
      @(posedge mclk_i);
      do_reset();
      rd(PPM_MODE_OFS);
      cmp("mode rerun", 32'h0, rdat);
      tally_and_finish();
   end
endmodule : ppm_port_test
